// file: rtl/phy_cnt_pkg.sv
// Purpose: Shared constants for the copper error counters and expansion window.
// Assumes: Avalon word addressing; register index equals the word address.
// Notes:   Byte address of a register is four times its index.
package phy_cnt_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;

  // Register indices.
  localparam logic [7:0]  IDX_TXERR       = 8'h13;
  localparam logic [7:0]  IDX_FAULT_CRC   = 8'h28;
  localparam logic [7:0]  IDX_EXP_DATA    = 8'h2A;
  localparam logic [7:0]  IDX_EXP_SEL     = 8'h2E;
  localparam logic [7:0]  IDX_CNT_MODE    = 8'h38;
  localparam logic [7:0]  IDX_CNT_SEL     = 8'h3C;
  localparam logic [7:0]  IDX_IRQ_STAT    = 8'h40;
  localparam logic [7:0]  IDX_IRQ_MASK    = 8'h41;

  // Field positions.
  localparam int          POS_COPPER_OFF  = 9;
  localparam int          POS_ALT_TXERR   = 14;
  localparam int          POS_SEL_CRC     = 15;
  localparam int          POS_EXP_SEL_LO  = 8;
  localparam int          EXP_SEL_W       = 4;
  localparam logic [3:0]  EXP_SEL_ON      = 4'hF;

  // Interrupt status bits: a counter has reached its ceiling.
  localparam int          IRQ_W           = 5;
  localparam int          IRQ_FALSE_CAR   = 0;
  localparam int          IRQ_TXERR       = 1;
  localparam int          IRQ_REMOTE      = 2;
  localparam int          IRQ_LOCAL       = 3;
  localparam int          IRQ_CRC         = 4;

  // Reset values and ceilings.
  localparam logic [15:0] RST_REG16       = 16'h0000;
  localparam logic [7:0]  CNT8_MAX        = 8'hFF;
  localparam logic [15:0] CRC_MAX_DEF     = 16'h00FF;

endpackage

// file: rtl/sat_count.sv
// Purpose: Saturating event counter that clears when software reads it.
// Assumes: Increment and clear are single-cycle strobes.
// Notes:   An event in the clearing cycle survives as a count of one.
module sat_count #(
  parameter int          W   = 8,
  parameter logic [15:0] MAX = 16'h00FF
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic         inc,
  input  wire logic         clr,
  output logic     [W-1:0]  count
);
  localparam logic [W-1:0] ONE  = W'(1);
  localparam logic [W-1:0] ZERO = '0;
  localparam logic [W-1:0] TOP  = MAX[W-1:0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= ZERO;
    end else if (clr) begin
      count <= inc ? ONE : ZERO;
    end else if (inc && count != TOP) begin
      count <= count + ONE;
    end
  end
endmodule

// file: rtl/rise_detect.sv
// Purpose: One-cycle pulse on each rising edge of a group of status levels.
// Assumes: Levels are synchronous to the clock.
// Notes:   Levels high at reset release do not give a pulse.
module rise_detect #(
  parameter int N = 2
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  input  wire logic [N-1:0]  level,
  output logic      [N-1:0]  pulse
);
  logic [N-1:0] prev_r;
  logic         armed_r;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      armed_r <= 1'b0;
    end else begin
      armed_r <= 1'b1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          prev_r[i] <= 1'b0;
          pulse[i]  <= 1'b0;
        end else begin
          prev_r[i] <= level[i];
          pulse[i]  <= armed_r && level[i] && !prev_r[i];
        end
      end
    end
  endgenerate
endmodule

// file: rtl/phy_err_counters.sv
// Purpose: Copper error statistics counters and the expansion register window.
// Assumes: Avalon-MM slave with word addresses; event inputs other than the fault levels are clean strobes.
// Notes:   Counters sharing an address are picked by the select register.
//
// Overview of operation
// - In copper mode with bit 14 set, count packets with transmit error codes.
// - With bit 14 clear, the same field counts false carrier events instead.
// - High byte of the fault register counts local receiver fault entries while bit 15 is 0.
// - Low byte of the fault register counts remote receiver fault detections while bit 15 is 0.
// - Address 28h shows fault pair when bit 15 is 0, CRC count otherwise.
// - CRC count advances once per received copper frame with a CRC error while bit 15 is 1.
// - Counters run only while the copper mode bit 9 reads zero.
// - Counters stop at their ceiling (FFh, or CRC_MAX for the CRC count) and never wrap.
// - Reading a counter returns its value and clears it; reset value zero.
// - Select field 1111 opens expansion register access through register 2Ah.
// - Low byte of the access register picks the expansion register number.
//
// Design decision made here: the Avalon-MM register port.
module phy_err_counters
  import phy_cnt_pkg::*;
#(
  parameter int          EXP_DEPTH = 16,
  parameter logic [15:0] CRC_MAX   = phy_cnt_pkg::CRC_MAX_DEF
) (
  // Clock and reset
  input  wire logic                             CLK,
  input  wire logic                             NRST,
  // Avalon-MM slave
  input  wire logic [phy_cnt_pkg::ADDR_W-1:0]   ADDRESS,
  input  wire logic                             READ,
  input  wire logic                             WRITE,
  input  wire logic [3:0]                       BYTEENABLE,
  input  wire logic [phy_cnt_pkg::DATA_W-1:0]   WRITEDATA,
  output logic      [phy_cnt_pkg::DATA_W-1:0]   READDATA,
  output logic                                  WAITREQUEST,
  // Receive events from the copper datapath
  input  wire logic                             TX_ERR_CODE_PKT,
  input  wire logic                             FALSE_CARRIER,
  input  wire logic                             RX_CRC_ERR,
  input  wire logic                             LOCAL_RX_FAULT,
  input  wire logic                             REMOTE_RX_FAULT,
  // Interrupt
  output logic                                  IRQ
);
  import phy_cnt_pkg::*;

  typedef enum logic [0:0] {
    BUS_IDLE,
    BUS_DONE
  } bus_state_t;

  localparam int          EXP_IW   = $clog2(EXP_DEPTH);
  localparam logic [15:0] ZERO16   = 16'h0000;
  localparam logic [31:0] ZERO32   = 32'h0000_0000;

  bus_state_t        bus_r;
  logic [15:0]       cnt_mode_r;
  logic [15:0]       cnt_sel_r;
  logic [15:0]       exp_sel_r;
  logic [IRQ_W-1:0]  irq_stat_r;
  logic [IRQ_W-1:0]  irq_mask_r;
  logic [15:0]       exp_mem_r [EXP_DEPTH];

  logic              take;
  logic              rd_take;
  logic              wr_take;
  logic [15:0]       wdata16;
  logic [15:0]       wmask16;
  logic [31:0]       rdata_nxt;

  logic              copper_on;
  logic              alt_txerr;
  logic              sel_crc;
  logic              exp_open;
  logic              exp_hit;
  logic [EXP_IW-1:0] exp_idx;

  logic [1:0]        fault_pulse;
  logic              inc_txerr;
  logic              inc_fcar;
  logic              inc_local;
  logic              inc_remote;
  logic              inc_crc;
  logic              clr_13;
  logic              clr_fault;
  logic              clr_crc;

  logic [7:0]        txerr_cnt;
  logic [7:0]        fcar_cnt;
  logic [7:0]        local_cnt;
  logic [7:0]        remote_cnt;
  logic [15:0]       crc_cnt;
  logic [IRQ_W-1:0]  irq_evt;

  // Bus handshake: one wait cycle, effects land at the edge that raises the answer.
  assign take    = (READ || WRITE) && (bus_r == BUS_IDLE);
  assign rd_take = take && READ;
  assign wr_take = take && WRITE;
  assign wmask16 = {{8{BYTEENABLE[1]}}, {8{BYTEENABLE[0]}}};
  assign wdata16 = WRITEDATA[15:0];

  // The request acts at the edge that takes it; the wait cycle only lets the answer be registered.
  // A master that still holds its request in the answer cycle is not taken twice, as the state is then done.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      bus_r <= BUS_IDLE;
    end else begin
      case (bus_r)
        BUS_IDLE: begin
          if (READ || WRITE) begin
            bus_r <= BUS_DONE;
          end
        end
        BUS_DONE: begin
          bus_r <= BUS_IDLE;
        end
        default: begin
          bus_r <= BUS_IDLE;
        end
      endcase
    end
  end

  // The answer is registered so that the port comes straight from a flip-flop.
  // This costs one wait cycle per access, which the management path can afford.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      WAITREQUEST <= 1'b1;
    end else begin
      WAITREQUEST <= !take;
    end
  end

  // Mode decoding.
  assign copper_on = !cnt_mode_r[POS_COPPER_OFF];
  assign alt_txerr = cnt_sel_r[POS_ALT_TXERR];
  assign sel_crc   = cnt_sel_r[POS_SEL_CRC];
  assign exp_open  = exp_sel_r[POS_EXP_SEL_LO +: EXP_SEL_W] == EXP_SEL_ON;
  assign exp_idx   = exp_sel_r[EXP_IW-1:0];
  // An index past the end of the store closes the window rather than aliasing onto a lower word.
  assign exp_hit   = exp_open && (exp_sel_r[7:0] < 8'(EXP_DEPTH));

  // Configuration registers.
  // Only bit 9 of the mode word and bits 14 and 15 of the select word steer the counters.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_mode_r <= RST_REG16;
    end else if (wr_take && ADDRESS == IDX_CNT_MODE) begin
      cnt_mode_r <= (cnt_mode_r & ~wmask16) | (wdata16 & wmask16);
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      cnt_sel_r <= RST_REG16;
    end else if (wr_take && ADDRESS == IDX_CNT_SEL) begin
      cnt_sel_r <= (cnt_sel_r & ~wmask16) | (wdata16 & wmask16);
    end
  end

  // Bits 15:12 are stored as written; software keeps them zero.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      exp_sel_r <= RST_REG16;
    end else if (wr_take && ADDRESS == IDX_EXP_SEL) begin
      exp_sel_r <= (exp_sel_r & ~wmask16) | (wdata16 & wmask16);
    end
  end

  // Expansion register contents are a plain store here; their meaning lives elsewhere.
  // Writes with the window closed or the index out of range are dropped.
  genvar e;
  generate
    for (e = 0; e < EXP_DEPTH; e++) begin : g_exp
      always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          exp_mem_r[e] <= RST_REG16;
        end else if (wr_take && ADDRESS == IDX_EXP_DATA && exp_hit && exp_idx == EXP_IW'(e)) begin
          exp_mem_r[e] <= (exp_mem_r[e] & ~wmask16) | (wdata16 & wmask16);
        end
      end
    end
  endgenerate

  // Event qualification.
  // Fault inputs are levels, so only entries into the fault state are counted.
  // A fault that lasts many cycles therefore counts once.
  rise_detect #(
    .N (2)
  ) u_fault_edge (
    .clk   (CLK),
    .nrst  (NRST),
    .level ({LOCAL_RX_FAULT, REMOTE_RX_FAULT}),
    .pulse (fault_pulse)
  );

  assign inc_txerr  = copper_on && alt_txerr && TX_ERR_CODE_PKT;
  assign inc_fcar   = copper_on && !alt_txerr && FALSE_CARRIER;
  assign inc_local  = copper_on && !sel_crc && fault_pulse[1];
  assign inc_remote = copper_on && !sel_crc && fault_pulse[0];
  assign inc_crc    = copper_on && sel_crc && RX_CRC_ERR;

  // Clearing reads touch only the counter that the read returned.
  // The select in force at the taking edge decides which counter is cleared.
  assign clr_13    = rd_take && ADDRESS == IDX_TXERR;
  assign clr_fault = rd_take && ADDRESS == IDX_FAULT_CRC && !sel_crc;
  assign clr_crc   = rd_take && ADDRESS == IDX_FAULT_CRC && sel_crc;

  // Deselected counters neither count nor clear, so they keep their value across a select change.
  sat_count #(
    .W   (8),
    .MAX ({8'h00, CNT8_MAX})
  ) u_txerr (
    .clk   (CLK),
    .nrst  (NRST),
    .inc   (inc_txerr),
    .clr   (clr_13 && alt_txerr),
    .count (txerr_cnt)
  );

  sat_count #(
    .W   (8),
    .MAX ({8'h00, CNT8_MAX})
  ) u_fcar (
    .clk   (CLK),
    .nrst  (NRST),
    .inc   (inc_fcar),
    .clr   (clr_13 && !alt_txerr),
    .count (fcar_cnt)
  );

  sat_count #(
    .W   (8),
    .MAX ({8'h00, CNT8_MAX})
  ) u_local (
    .clk   (CLK),
    .nrst  (NRST),
    .inc   (inc_local),
    .clr   (clr_fault),
    .count (local_cnt)
  );

  sat_count #(
    .W   (8),
    .MAX ({8'h00, CNT8_MAX})
  ) u_remote (
    .clk   (CLK),
    .nrst  (NRST),
    .inc   (inc_remote),
    .clr   (clr_fault),
    .count (remote_cnt)
  );

  // The ceiling of the wide CRC count is a parameter since its true limit is unsettled.
  sat_count #(
    .W   (16),
    .MAX (CRC_MAX)
  ) u_crc (
    .clk   (CLK),
    .nrst  (NRST),
    .inc   (inc_crc),
    .clr   (clr_crc),
    .count (crc_cnt)
  );

  // Read multiplexer; unmapped words and a closed window read as zero.
  always_comb begin
    rdata_nxt = ZERO32;
    case (ADDRESS)
      IDX_TXERR: begin
        rdata_nxt[7:0] = alt_txerr ? txerr_cnt : fcar_cnt;
      end
      IDX_FAULT_CRC: begin
        rdata_nxt[15:0] = sel_crc ? crc_cnt : {local_cnt, remote_cnt};
      end
      IDX_EXP_DATA: begin
        rdata_nxt[15:0] = exp_hit ? exp_mem_r[exp_idx] : ZERO16;
      end
      IDX_EXP_SEL: begin
        rdata_nxt[15:0] = exp_sel_r;
      end
      IDX_CNT_MODE: begin
        rdata_nxt[15:0] = cnt_mode_r;
      end
      IDX_CNT_SEL: begin
        rdata_nxt[15:0] = cnt_sel_r;
      end
      IDX_IRQ_STAT: begin
        rdata_nxt[IRQ_W-1:0] = irq_stat_r;
      end
      IDX_IRQ_MASK: begin
        rdata_nxt[IRQ_W-1:0] = irq_mask_r;
      end
      default: begin
        rdata_nxt = ZERO32;
      end
    endcase
  end

  // Read data is held until the next read is taken, so a late sample still sees it.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      READDATA <= ZERO32;
    end else if (rd_take) begin
      READDATA <= rdata_nxt;
    end
  end

  // Ceiling events: a counter that is about to reach its maximum.
  // Raising the flag on the step onto the ceiling, not on the ceiling itself, keeps a
  // parked counter from raising it again after software has cleared the status bit.
  assign irq_evt[IRQ_FALSE_CAR] = inc_fcar && fcar_cnt == CNT8_MAX - 8'h01;
  assign irq_evt[IRQ_TXERR]     = inc_txerr && txerr_cnt == CNT8_MAX - 8'h01;
  assign irq_evt[IRQ_REMOTE]    = inc_remote && remote_cnt == CNT8_MAX - 8'h01;
  assign irq_evt[IRQ_LOCAL]     = inc_local && local_cnt == CNT8_MAX - 8'h01;
  assign irq_evt[IRQ_CRC]       = inc_crc && crc_cnt == CRC_MAX - 16'h0001;

  // Sticky status; a new event wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      irq_stat_r <= '0;
    end else if (wr_take && ADDRESS == IDX_IRQ_STAT && BYTEENABLE[0]) begin
      irq_stat_r <= (irq_stat_r & ~WRITEDATA[IRQ_W-1:0]) | irq_evt;
    end else begin
      irq_stat_r <= irq_stat_r | irq_evt;
    end
  end

  // The mask only gates the pin; status bits keep latching while masked.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      irq_mask_r <= '0;
    end else if (wr_take && ADDRESS == IDX_IRQ_MASK && BYTEENABLE[0]) begin
      irq_mask_r <= WRITEDATA[IRQ_W-1:0];
    end
  end

  // The interrupt lags the status by one cycle so that the pin stays registered.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_stat_r & irq_mask_r);
    end
  end
endmodule

// file: verif/phy_err_counters_asserts.sv
// Purpose: Bus, window and interrupt relations checked at the counter block ports.
// Assumes: Masters write full 16-bit words to the shadowed registers.
// Notes:   Shadows of select and mask registers are rebuilt from bus writes.
module phy_err_counters_chk
  import phy_cnt_pkg::*;
(
  // Clock and reset
  input  wire logic                           CLK,
  input  wire logic                           NRST,
  // Bus
  input  wire logic [phy_cnt_pkg::ADDR_W-1:0] ADDRESS,
  input  wire logic                           READ,
  input  wire logic                           WRITE,
  input  wire logic [phy_cnt_pkg::DATA_W-1:0] WRITEDATA,
  input  wire logic [phy_cnt_pkg::DATA_W-1:0] READDATA,
  input  wire logic                           WAITREQUEST,
  // Events and interrupt
  input  wire logic                           TX_ERR_CODE_PKT,
  input  wire logic                           FALSE_CARRIER,
  input  wire logic                           IRQ
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        rd_take;
  logic        wr_take;
  logic        sel_evt;
  logic        unmapped;
  logic [15:0] win_r;
  logic [4:0]  mask_r;
  logic        alt_r;
  logic        clean_r;
  assign rd_take  = READ && WAITREQUEST;
  assign wr_take  = WRITE && WAITREQUEST;
  assign sel_evt  = alt_r ? TX_ERR_CODE_PKT : FALSE_CARRIER;
  assign unmapped = !(ADDRESS inside {IDX_TXERR, IDX_FAULT_CRC, IDX_EXP_DATA, IDX_EXP_SEL, IDX_CNT_MODE,
                                      IDX_CNT_SEL, IDX_IRQ_STAT, IDX_IRQ_MASK});
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      win_r  <= 16'h0000;
      mask_r <= 5'h00;
      alt_r  <= 1'b0;
    end else if (wr_take) begin
      if (ADDRESS == IDX_EXP_SEL) win_r <= WRITEDATA[15:0];
      if (ADDRESS == IDX_IRQ_MASK) mask_r <= WRITEDATA[4:0];
      if (ADDRESS == IDX_CNT_SEL) alt_r <= WRITEDATA[POS_ALT_TXERR];
    end
  end
  // Any event of the selected kind, even one that should be ignored, spoils the clean mark; that keeps this side conservative.
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) clean_r <= 1'b0;
    else if (sel_evt || (wr_take && (ADDRESS == IDX_CNT_SEL || ADDRESS == IDX_CNT_MODE))) clean_r <= 1'b0;
    else if (rd_take && ADDRESS == IDX_TXERR) clean_r <= 1'b1;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  property p_ack_next; (READ || WRITE) && WAITREQUEST |=> !WAITREQUEST; endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not answered in one cycle");
  property p_ack_single; !WAITREQUEST |=> WAITREQUEST; endproperty
  a_ack_single: assert property (p_ack_single) else $error("answer lasted more than one cycle");
  property p_ack_cause; !WAITREQUEST |-> $past(READ || WRITE) && $past(WAITREQUEST); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("answer without a request");
  property p_upper_zero; !WAITREQUEST |-> READDATA[31:16] == 16'h0000; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read half not zero");
  property p_unmapped; rd_take && unmapped |=> READDATA == 32'h0000_0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_window_closed; rd_take && ADDRESS == IDX_EXP_DATA && win_r[11:8] != EXP_SEL_ON |=> READDATA == 32'h0; endproperty
  a_window_closed: assert property (p_window_closed) else $error("closed window returned data");
  property p_clear_on_read; rd_take && ADDRESS == IDX_TXERR && clean_r |=> READDATA[7:0] == 8'h00; endproperty
  a_clear_on_read: assert property (p_clear_on_read) else $error("count survived a read");
  property p_field_width; rd_take && ADDRESS == IDX_TXERR |=> READDATA[15:8] == 8'h00; endproperty
  a_field_width: assert property (p_field_width) else $error("reserved count bits set");
  property p_irq_mask; IRQ |-> $past(mask_r) != 5'h00; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt with all sources masked");
endmodule

bind phy_err_counters phy_err_counters_chk u_chk (.CLK(CLK), .NRST(NRST), .ADDRESS(ADDRESS), .READ(READ),
  .WRITE(WRITE), .WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
  .TX_ERR_CODE_PKT(TX_ERR_CODE_PKT), .FALSE_CARRIER(FALSE_CARRIER), .IRQ(IRQ));

// file: verif/test_phy_err_counters.sv
// Purpose: Self-checking bench for the copper error counters and expansion window.
// Assumes: Full word writes; events are one-cycle pulses a cycle apart.
// Notes:   Expected counts come from the bench's own integer model.
module test_phy_err_counters
  import phy_cnt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              CLK = 1'b0;
  logic              NRST = 1'b0;
  logic [ADDR_W-1:0] ADDRESS = 8'h00;
  logic              READ = 1'b0;
  logic              WRITE = 1'b0;
  logic [DATA_W-1:0] WRITEDATA = 32'h0;
  logic [4:0]        ev = 5'h00;
  wire  logic [DATA_W-1:0] READDATA;
  wire  logic        WAITREQUEST;
  wire  logic        IRQ;
  logic [31:0]       rd;
  logic [7:0]        regs [8] = '{IDX_TXERR, IDX_FAULT_CRC, IDX_EXP_DATA, IDX_EXP_SEL, IDX_CNT_MODE,
                                  IDX_CNT_SEL, IDX_IRQ_STAT, IDX_IRQ_MASK};
  int                err_total = 0;
  int                samples_checked = 0;
  int                seed = 38266;
  int                n;
  int                m;
  int                k;
  int                exp_q[$];
  always #25 CLK = ~CLK;
  phy_err_counters DUT (.CLK(CLK), .NRST(NRST), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
    .BYTEENABLE(4'hF), .WRITEDATA(WRITEDATA), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
    .TX_ERR_CODE_PKT(ev[IRQ_TXERR]), .FALSE_CARRIER(ev[IRQ_FALSE_CAR]), .RX_CRC_ERR(ev[IRQ_CRC]),
    .LOCAL_RX_FAULT(ev[IRQ_LOCAL]), .REMOTE_RX_FAULT(ev[IRQ_REMOTE]), .IRQ(IRQ));

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // An event mask given here is pulsed so that it lands on the edge that takes the request.
  task automatic bus(input bit wr, input logic [7:0] a, input logic [15:0] d, input logic [4:0] evm);
    int i;
    @(posedge CLK);
    ADDRESS <= a;
    WRITE <= wr;
    READ <= !wr;
    WRITEDATA <= {16'h0000, d};
    ev <= evm;
    for (i = 0; i < 20; i++) begin
      @(posedge CLK);
      ev <= 5'h00;
      if (WAITREQUEST === 1'b0) break;
    end
    if (i == 20) begin
      err_total++;
      end_of_test();
    end
    rd = READDATA;
    READ <= 1'b0;
    WRITE <= 1'b0;
  endtask
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d, 5'h00);
  endtask
  task automatic rd_chk(input logic [7:0] a, input int exp);
    bus(1'b0, a, 16'h0000, 5'h00);
    chk(rd, exp);
  endtask
  task automatic pulse(input logic [4:0] msk, input int cnt);
    repeat (cnt) begin
      @(posedge CLK);
      ev <= msk;
      @(posedge CLK);
      ev <= 5'h00;
    end
    repeat (3) @(posedge CLK);
  endtask
  task automatic irq_chk(input int exp);
    repeat (2) @(posedge CLK);
    @(negedge CLK);
    chk({31'h0, IRQ}, exp);
  endtask

  initial begin
    repeat (100000) @(posedge CLK);
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (5) @(posedge CLK);
    NRST <= 1'b1;
    foreach (regs[i]) rd_chk(regs[i], 0);
    $display("test reset_values done");
    for (k = 0; k < 2; k++) begin
      wr16(IDX_CNT_SEL, k ? 16'h4000 : 16'h0000);
      n = 1 + $unsigned($random(seed)) % 10;
      pulse(5'b00011, n);
      rd_chk(IDX_TXERR, n);
      rd_chk(IDX_TXERR, 0);
    end
    $display("test packet_counts done");
    wr16(IDX_CNT_SEL, 16'h0000);
    n = 1 + $unsigned($random(seed)) % 8;
    m = 1 + $unsigned($random(seed)) % 8;
    pulse(5'b01000, n);
    pulse(5'b00100, m);
    rd_chk(IDX_FAULT_CRC, (n << 8) | m);
    wr16(IDX_CNT_SEL, 16'h8000);
    n = 1 + $unsigned($random(seed)) % 12;
    pulse(5'b11100, n);
    rd_chk(IDX_FAULT_CRC, n);
    wr16(IDX_CNT_SEL, 16'h0000);
    rd_chk(IDX_FAULT_CRC, 0);
    $display("test fault_crc done");
    wr16(IDX_CNT_MODE, 16'h0200);
    wr16(IDX_CNT_SEL, 16'h4000);
    pulse(5'b11111, 5);
    wr16(IDX_CNT_MODE, 16'h0000);
    rd_chk(IDX_TXERR, 0);
    rd_chk(IDX_FAULT_CRC, 0);
    wr16(IDX_CNT_SEL, 16'h8000);
    rd_chk(IDX_FAULT_CRC, 0);
    wr16(IDX_CNT_SEL, 16'h0000);
    rd_chk(IDX_TXERR, 0);
    $display("test mode_off done");
    for (k = 0; k < 2; k++) begin
      wr16(IDX_CNT_SEL, k ? 16'h8000 : 16'h4000);
      wr16(IDX_IRQ_MASK, 16'h0000);
      pulse(k ? 5'b10000 : 5'b00010, 260);
      irq_chk(0);
      wr16(IDX_IRQ_MASK, k ? 16'h0010 : 16'h0002);
      irq_chk(1);
      rd_chk(IDX_IRQ_STAT, k ? 16'h0010 : 16'h0002);
      wr16(IDX_IRQ_STAT, k ? 16'h0010 : 16'h0002);
      irq_chk(0);
      rd_chk(k ? IDX_FAULT_CRC : IDX_TXERR, 8'hFF);
    end
    $display("test saturation done");
    wr16(IDX_CNT_SEL, 16'h4000);
    bus(1'b0, IDX_TXERR, 16'h0000, 5'b00010);
    chk(rd, 0);
    rd_chk(IDX_TXERR, 1);
    $display("test read_race done");
    for (k = 5; k < 7; k++) begin
      wr16(IDX_EXP_SEL, 16'h0F00 | k);
      exp_q.push_back($unsigned($random(seed)) & 16'hFFFF);
      wr16(IDX_EXP_DATA, exp_q[$]);
    end
    for (k = 5; k < 7; k++) begin
      wr16(IDX_EXP_SEL, 16'h0F00 | k);
      rd_chk(IDX_EXP_DATA, exp_q.pop_front());
    end
    // An index past the store is refused and must not alias onto word zero.
    wr16(IDX_EXP_SEL, 16'h0F40);
    wr16(IDX_EXP_DATA, 16'h1234);
    rd_chk(IDX_EXP_DATA, 0);
    wr16(IDX_EXP_SEL, 16'h0F00);
    rd_chk(IDX_EXP_DATA, 0);
    wr16(IDX_EXP_SEL, 16'h0006);
    rd_chk(IDX_EXP_DATA, 0);
    rd_chk(IDX_EXP_SEL, 16'h0006);
    wr16(8'h00, 16'hFFFF);
    rd_chk(8'h00, 0);
    $display("test expansion done");
    end_of_test();
  end
endmodule
